// ===== test/bus_partner.sv
// Far-side bus model: other masters and slaves seen as event pulses
`timescale 1ns/1ps
module bus_partner
   import i2c_start_pkg::*;
(
   // Clock
   input  wire logic                    clk,
   // Bus side
   output i2c_start_pkg::bus_event_type ev,
   output logic                         scl,
   output logic                         sda
);
   // Idle bus between frames, both lines pulled high
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
      ev  = '0;
   end

   // Lines held low stand for a transfer by others in progress
   task automatic set_lines(input logic level);
      @(negedge clk);
      scl = level;
      sda = level;
   endtask

   // Kinds: 0 start, 1 stop, 2 address, 3 arbitration loss, 4 data write
   task automatic pulse(input int kind, input logic [6:0] a);
      @(negedge clk);
      ev            = '0;
      ev.start_seen = (kind == 0);
      ev.stop_seen  = (kind == 1);
      ev.addr_done  = (kind == 2);
      ev.arb_lost   = (kind == 3);
      ev.data_write = (kind == 4);
      ev.addr       = a;
      @(negedge clk);
      ev            = '0;
      // Stale address would hide a sampling slip
      ev.addr       = ~a;
   endtask
endmodule

// ===== test/i2c_start_ctrl_properties.sv
// Checker on the start-control ports, bound below
`timescale 1ns/1ps
module i2c_start_ctrl_properties
   import i2c_start_pkg::*;
#(
   parameter int ADDR_W = 7
)
(
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         rst,
   // Watched inputs
   input wire i2c_start_pkg::ctrl_type      ctrl,
   input wire logic [ADDR_W-1:0]            local_addr,
   input wire i2c_start_pkg::bus_event_type bus_ev,
   input wire logic                         serial_clock_line,
   input wire logic                         serial_data_line,
   // Watched outputs
   input wire i2c_start_pkg::status_type    status,
   input wire logic                         i2c_event_irq,
   input wire logic                         gen_start,
   input wire logic                         addr_xfer_start
);
   logic standby_r;
   logic standby_nxt;
   logic hit;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Standby from a start until its address byte ends
   always_comb
   begin
      standby_nxt = standby_r;
      if (bus_ev.start_seen)
         standby_nxt = 1'b1;
      else if (bus_ev.addr_done)
         standby_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         standby_r <= 1'b0;
      else
         standby_r <= standby_nxt;
   end

   assign hit = bus_ev.addr == local_addr[6:0]
                || bus_ev.addr[6:3] == EXT_LOW_NIB
                || bus_ev.addr[6:3] == EXT_HIGH_NIB;

   sequence s_wake;
      bus_ev.addr_done && standby_r && hit && ctrl.unit_enable;
   endsequence

   sequence s_miss;
      (bus_ev.addr_done && standby_r && !hit) ##1 !bus_ev.stop_seen;
   endsequence

   a_wake_irq: assert property (s_wake |-> ##2 i2c_event_irq)
      else $error("address match gave no event");
   a_wake_miss: assert property (s_miss |=> !i2c_event_irq)
      else $error("event raised for a foreign address");
   a_stop_irq: assert property (
      bus_ev.stop_seen && ctrl.stop_irq_enable && ctrl.unit_enable
      |=> i2c_event_irq)
      else $error("enabled stop gave no event");
   a_stop_silent: assert property (
      bus_ev.stop_seen && !ctrl.stop_irq_enable && !$past(bus_ev.addr_done)
      |=> !i2c_event_irq)
      else $error("masked stop raised an event");
   a_free_enable: assert property (
      $rose(ctrl.unit_enable) && ctrl.start_without_stop_enable
      && !bus_ev.start_seen
      |=> !status.bus_busy_flag)
      else $error("bus busy after stop-less enable");
   a_busy_enable: assert property (
      $rose(ctrl.unit_enable) && !ctrl.start_without_stop_enable
      && $past(serial_clock_line, 2) && $past(serial_data_line, 2)
      |-> ##[1:3] status.bus_busy_flag)
      else $error("bus not busy after enable");
   a_xfer_release: assert property (
      status.waiting && bus_ev.data_write && ctrl.unit_enable
      |=> addr_xfer_start && !status.waiting)
      else $error("data write did not release the wait");
   a_fail_quiet: assert property (
      $rose(status.start_failure_flag)
      |-> (!status.master_state_flag && !gen_start) [*4])
      else $error("rejected request still started");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst |=> status == '0 && !gen_start && !i2c_event_irq)
      else $error("outputs active after reset");
endmodule

bind i2c_start_ctrl i2c_start_ctrl_properties #(.ADDR_W(ADDR_W)) chk_u (
   .clk, .rst, .ctrl, .local_addr, .bus_ev, .serial_clock_line,
   .serial_data_line, .status, .i2c_event_irq, .gen_start, .addr_xfer_start
);

// ===== test/i2c_start_ctrl_tb.sv
// Self-checking bench for the start-control block
`timescale 1ns/1ps
module i2c_start_ctrl_tb;
   import i2c_start_pkg::*;
   localparam logic [3:0] MODES [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hC};
   logic          clk;
   logic          rst;
   ctrl_type      c;
   ctrl_type      k;
   logic [6:0]    la;
   logic [6:0]    a;
   bus_event_type ev;
   logic          scl;
   logic          sda;
   status_type    st;
   logic          irq;
   logic          gs;
   logic          axs;
   int            bad_count = 0;
   int            num_checks = 0;
   int            irqs = 0;
   int            gens = 0;
   int            xfers = 0;
   int            g;
   int            h;

   i2c_start_ctrl #(.ADDR_W(7)) dut_u (
      .clk(clk), .rst(rst), .ctrl(c), .local_addr(la), .bus_ev(ev),
      .serial_clock_line(scl), .serial_data_line(sda), .status(st),
      .i2c_event_irq(irq), .gen_start(gs), .addr_xfer_start(axs)
   );
   bus_partner pt_u (.clk(clk), .ev(ev), .scl(scl), .sda(sda));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Pulses are counted, so checks need not hit their exact cycle
   always @(posedge clk)
   begin
      irqs  += int'(irq === 1'b1);
      gens  += int'(gs === 1'b1);
      xfers += int'(axs === 1'b1);
   end

   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t check %0d differs", $time, num_checks);
      end
   endtask

   task automatic tally_and_finish();
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Software wait before the decision flags may be read
   function automatic int wlen();
      if (c.prescaler_enable)
         return 6 + 3 * c.prescaler_select;
      if (c.reservation_disable)
         return 3;
      if (c.clock_extension_bit)
         return 10;
      if (c.fast_mode_select)
         return 16;
      if (c.clock_select_high | c.clock_select_low)
         return 47;
      return 26;
   endfunction

   task automatic enable(input ctrl_type cfg);
      @(negedge clk);
      c.unit_enable = 1'b0;
      @(negedge clk);
      cfg.unit_enable = 1'b0;
      c = cfg;
      repeat (2) @(negedge clk);
      c.unit_enable = 1'b1;
      repeat (4) @(negedge clk);
   endtask

   task automatic start_req(input logic exp_m, input logic exp_f);
      int n;
      n = gens;
      @(negedge clk);
      c.start_request = 1'b1;
      repeat (wlen() + 4) @(negedge clk);
      chk(st.master_state_flag, exp_m);
      chk(st.start_failure_flag, exp_f);
      chk(gens != n, exp_m);
      c.start_request = 1'b0;
   endtask

   initial
   begin
      c   = '0;
      rst = 1'b1;
      la  = 7'h00;
      void'($urandom(84838));
      repeat (10) @(negedge clk);
      rst = 1'b0;
      k = '0;
      k.reservation_disable = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         k.prescaler_enable = (i < 4);
         k.prescaler_select = 2'(i);
         enable(k);
         chk(st.bus_busy_flag, 1'b1);
         start_req(1'b0, 1'b1);
      end
      c.stop_request = 1'b1;
      repeat (2) @(negedge clk);
      chk(st.bus_busy_flag, 1'b0);
      c.stop_request = 1'b0;
      start_req(1'b1, 1'b0);
      pt_u.pulse(3, 7'h00);
      @(negedge clk);
      chk(st.master_state_flag, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         k = '0;
         k.start_without_stop_enable = 1'b1;
         {k.clock_extension_bit, k.fast_mode_select, k.clock_select_high,
            k.clock_select_low} = MODES[i];
         enable(k);
         chk(st.bus_busy_flag, 1'b0);
         start_req(1'b1, 1'b0);
         g = xfers;
         // One mode releases by the wait release bit, no transfer then
         if (i == 4)
         begin
            c.wait_release = 1'b1;
            @(negedge clk);
            c.wait_release = 1'b0;
            @(negedge clk);
         end
         else
         begin
            pt_u.pulse(4, 7'h00);
            repeat (2) @(negedge clk);
         end
         chk(xfers == g + int'(i != 4) && st.waiting == 1'b0, 1'b1);
      end
      k = '0;
      k.stop_irq_enable = 1'b1;
      enable(k);
      pt_u.pulse(0, 7'h00);
      chk(st.start_detected_flag, 1'b1);
      start_req(1'b0, 1'b0);
      g = gens;
      h = irqs;
      pt_u.pulse(1, 7'h00);
      repeat (3) @(negedge clk);
      chk(gens == g + 1 && irqs == h + 1, 1'b1);
      g = xfers;
      pt_u.pulse(4, 7'h00);
      repeat (2) @(negedge clk);
      chk(xfers == g + 1, 1'b1);
      c.leave_bus = 1'b1;
      @(negedge clk);
      c.leave_bus = 1'b0;
      chk(st.master_state_flag, 1'b0);
      k = '0;
      k.start_without_stop_enable = 1'b1;
      enable(k);
      for (int i = 0; i < 8; i++)
      begin
         la = {4'h3, 3'($urandom)};
         a  = {4'h5, 3'($urandom)};
         if (i % 4 == 0)
            a = la;
         if (i % 4 == 1)
            a[6:3] = 4'h0;
         if (i % 4 == 2)
            a[6:3] = 4'hF;
         h = irqs + int'(i % 4 != 3);
         pt_u.pulse(0, 7'h00);
         pt_u.pulse(2, a);
         repeat (3) @(negedge clk);
         chk(irqs == h, 1'b1);
         chk(st.extension_code_flag, i % 4 == 1 || i % 4 == 2);
         pt_u.pulse(1, 7'h00);
         repeat (3) @(negedge clk);
         chk(irqs == h, 1'b1);
      end
      // Enable while others hold the bus low assumes no busy state
      pt_u.set_lines(1'b0);
      k = '0;
      enable(k);
      chk(st.bus_busy_flag, 1'b0);
      pt_u.set_lines(1'b1);
      tally_and_finish();
   end

   // Whole run is under 2000 cycles; this allows five times that
   initial
   begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
endmodule

// ===== verilog/i2c_addr_filter.sv
// Wakeup address filter: match on local address or extension code
`timescale 1ns/1ps
module i2c_addr_filter
   import i2c_start_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Address in
   input  wire logic       addr_done,
   input  wire logic [6:0] addr,
   input  wire logic [6:0] local_addr,
   // Results
   output logic            wake_pulse,
   output logic            ext_code
);

   logic wake_r;
   logic wake_nxt;
   logic ext_r;
   logic ext_nxt;

   function automatic logic is_ext(input logic [6:0] a);
      is_ext = (a[6:3] == EXT_LOW_NIB) || (a[6:3] == EXT_HIGH_NIB);
   endfunction

   always_comb
   begin
      wake_nxt = addr_done && (is_ext(addr) || addr == local_addr); // [R1]
      ext_nxt  = addr_done && is_ext(addr); // [R20]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wake_r <= 1'b0;
         ext_r  <= 1'b0;
      end
      else
      begin
         wake_r <= wake_nxt;
         ext_r  <= ext_nxt;
      end
   end

   assign wake_pulse = wake_r;
   assign ext_code   = ext_r;

endmodule

// ===== verilog/i2c_start_ctrl.sv
// Start control: wakeup, reservation, start rejection and enable handling
`timescale 1ns/1ps
// What this block does
// [R1] Slave irq only on address match or extension
// [R2] Start detection enters wakeup standby through address
// [R3] Stop irq governed only by stop enable
// [R4] Reserved start waits for stop, then starts
// [R5] Data write after stop starts address transfer
// [R6] Start request chooses immediate start or reservation
// [R7] Software waits before reading master state flag
// [R8] Reservation accepted between start detect and stop
// [R9] Reservation disabled: busy start request rejected
// [R10] Arbitration loss or leave-bus frees device
// [R11] Start failure flag reports rejection after wait
// [R12] Stop-less start disabled: busy at enable while both lines high
// [R13] Master before stop: clock, enable, stop
// [R14] Stop-less start enabled: free at enable
// [R15] Enable only while both lines high
// [R16] Change clock only while disabled
// [R17] Request bits cleared before being set again
// [R18] Reserved transfer released by data write
// [R19] Master state flag valid without stop irq
// [R20] Nibble 0000 or 1111 marks extension code
// [R21] Wait release, data write or master request
module i2c_start_ctrl
   import i2c_start_pkg::*;
#(
   parameter int ADDR_W = 7
)
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Software side
   input  wire i2c_start_pkg::ctrl_type    ctrl,
   input  wire logic [ADDR_W-1:0]          local_addr,
   // Bus events, already on clk
   input  wire i2c_start_pkg::bus_event_type bus_ev,
   // Bus pins
   input  wire logic                       serial_clock_line,
   input  wire logic                       serial_data_line,
   // Outputs
   output i2c_start_pkg::status_type       status,
   output logic                            i2c_event_irq,
   output logic                            gen_start,
   output logic                            addr_xfer_start
);
   import i2c_start_pkg::*;

   // Filter compares 7 bits only; wider addresses are refused
   if (ADDR_W != 7)
   begin : g_width_check
      $error("Only 7-bit addresses are served");
   end

   // Pin synchronisers
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic       lines_high;

   // Request edge detection
   logic start_req_d_r;
   logic stop_req_d_r;
   logic en_d_r;
   logic start_rise;
   logic stop_rise;
   logic en_rise;

   // Main state
   start_state_type state_r;
   start_state_type state_nxt;
   logic            busy_r;
   logic            busy_nxt;
   logic            master_r;
   logic            master_nxt;
   logic            std_r;
   logic            std_nxt;
   logic            fail_r;
   logic            fail_nxt;
   logic            exc_r;
   logic            exc_nxt;
   logic            standby_r;
   logic            standby_nxt;
   logic            irq_r;
   logic            irq_nxt;
   logic            gen_r;
   logic            gen_nxt;
   logic            xfer_r;
   logic            xfer_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] decide_len;
   logic            wake_pulse;
   logic            ext_code;
   logic            release_ev;
   logic            waiting_r;
   logic            waiting_nxt;

   i2c_addr_filter u_filter
   (
      .clk        (clk),
      .rst        (rst),
      .addr_done  (bus_ev.addr_done && standby_r),
      .addr       (bus_ev.addr),
      .local_addr (local_addr),
      .wake_pulse (wake_pulse),
      .ext_code   (ext_code)
   );

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         scl_sync_r    <= 2'h0;
         sda_sync_r    <= 2'h0;
         start_req_d_r <= 1'b0;
         stop_req_d_r  <= 1'b0;
         en_d_r        <= 1'b0;
      end
      else
      begin
         scl_sync_r    <= {scl_sync_r[0], serial_clock_line};
         sda_sync_r    <= {sda_sync_r[0], serial_data_line};
         start_req_d_r <= ctrl.start_request;
         stop_req_d_r  <= ctrl.stop_request;
         en_d_r        <= ctrl.unit_enable;
      end
   end

   // Enable edge is only honoured while both lines idle high
   assign lines_high = scl_sync_r[1] && sda_sync_r[1]; // [R15]
   // Rising edges only; re-setting an already set bit is ignored
   assign start_rise = ctrl.start_request && !start_req_d_r; // [R17]
   assign stop_rise  = ctrl.stop_request && !stop_req_d_r; // [R17]
   assign en_rise    = ctrl.unit_enable && !en_d_r && lines_high;

   // Decision delay mirrors the documented software wait
   always_comb
   begin
      decide_len = CNT_W'(FAIL_NOPRE_CLKS);
      if (ctrl.prescaler_enable)
         decide_len = CNT_W'(FAIL_BASE_CLKS
                      + FAIL_STEP_CLKS * int'(ctrl.prescaler_select)); // [R11]
      else if (!ctrl.reservation_disable)
      begin
         if (ctrl.clock_extension_bit)
            decide_len = CNT_W'(WAIT_EXT_CLKS); // [R7]
         else if (ctrl.fast_mode_select)
            decide_len = CNT_W'(WAIT_FAST_CLKS);
         else if (ctrl.clock_select_low || ctrl.clock_select_high)
            decide_len = CNT_W'(WAIT_STD_LOW_CLKS);
         else
            decide_len = CNT_W'(WAIT_STD_CLKS);
      end
   end

   // Wait release sources; request bits release only as master
   assign release_ev = ctrl.wait_release || bus_ev.data_write
                       || (master_r && (start_rise || stop_rise)); // [R21]

   always_comb
   begin
      state_nxt   = state_r;
      busy_nxt    = busy_r;
      master_nxt  = master_r;
      std_nxt     = std_r;
      fail_nxt    = fail_r;
      exc_nxt     = exc_r;
      standby_nxt = standby_r;
      irq_nxt     = 1'b0;
      gen_nxt     = 1'b0;
      xfer_nxt    = 1'b0;
      cnt_nxt     = cnt_r;

      if (!ctrl.unit_enable)
      begin
         state_nxt   = ST_IDLE;
         master_nxt  = 1'b0;
         std_nxt     = 1'b0;
         fail_nxt    = 1'b0;
         exc_nxt     = 1'b0;
         standby_nxt = 1'b0;
         busy_nxt    = RST_BUSY;
      end
      else
      begin
         if (en_rise)
            busy_nxt = !ctrl.start_without_stop_enable; // [R12] [R14]
         if (bus_ev.start_seen)
         begin
            busy_nxt    = 1'b1;
            std_nxt     = 1'b1;
            standby_nxt = 1'b1; // [R2]
         end
         if (bus_ev.addr_done)
            standby_nxt = 1'b0;
         if (wake_pulse)
            irq_nxt = 1'b1; // [R1]
         if (ext_code)
            exc_nxt = 1'b1; // [R20]
         if (bus_ev.stop_seen)
         begin
            busy_nxt = 1'b0;
            std_nxt  = 1'b0;
            exc_nxt  = 1'b0;
            if (ctrl.stop_irq_enable)
               irq_nxt = 1'b1; // [R3]
         end
         if (bus_ev.arb_lost || ctrl.leave_bus)
            master_nxt = 1'b0; // [R10]

         unique case (state_r)
            ST_IDLE:
            begin
               if (start_rise)
               begin
                  state_nxt = ST_DECIDE; // [R6]
                  cnt_nxt   = decide_len;
                  fail_nxt  = 1'b0;
               end
               else if (stop_rise)
                  busy_nxt = 1'b0; // [R13]
            end
            ST_DECIDE:
            begin
               if (cnt_r > CNT_W'(1))
                  cnt_nxt = cnt_r - CNT_W'(1);
               else if (!busy_r)
               begin
                  state_nxt  = ST_WAIT;
                  master_nxt = 1'b1;
                  gen_nxt    = 1'b1;
                  busy_nxt   = 1'b1;
               end
               else if (ctrl.reservation_disable)
               begin
                  state_nxt = ST_IDLE;
                  fail_nxt  = 1'b1; // [R9] [R11]
               end
               else if (std_r)
                  state_nxt = ST_RESERVED; // [R8]
               else
                  state_nxt = ST_RESERVED; // [R4]
            end
            ST_RESERVED:
            begin
               if (bus_ev.stop_seen)
               begin
                  state_nxt  = ST_WAIT; // [R4]
                  master_nxt = 1'b1; // [R19]
                  gen_nxt    = 1'b1;
                  busy_nxt   = 1'b1;
               end
               else if (bus_ev.arb_lost)
                  state_nxt = ST_IDLE;
            end
            ST_WAIT:
            begin
               if (release_ev)
               begin
                  state_nxt = ST_MASTER;
                  xfer_nxt  = bus_ev.data_write; // [R5] [R18]
               end
            end
            ST_MASTER:
            begin
               if (!master_r || bus_ev.stop_seen)
                  state_nxt = ST_IDLE;
               else if (stop_rise)
                  state_nxt = ST_IDLE;
            end
            default:
               state_nxt = ST_IDLE;
         endcase
      end
      // Registered so the status output comes from a flip-flop
      waiting_nxt = (state_nxt == ST_WAIT);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r   <= ST_IDLE;
         busy_r    <= RST_BUSY;
         master_r  <= RST_MASTER;
         std_r     <= 1'b0;
         fail_r    <= 1'b0;
         exc_r     <= 1'b0;
         standby_r <= 1'b0;
         irq_r     <= 1'b0;
         gen_r     <= 1'b0;
         xfer_r    <= 1'b0;
         cnt_r     <= '0;
         waiting_r <= 1'b0;
      end
      else
      begin
         state_r   <= state_nxt;
         busy_r    <= busy_nxt;
         master_r  <= master_nxt;
         std_r     <= std_nxt;
         fail_r    <= fail_nxt;
         exc_r     <= exc_nxt;
         standby_r <= standby_nxt;
         irq_r     <= irq_nxt;
         gen_r     <= gen_nxt;
         xfer_r    <= xfer_nxt;
         cnt_r     <= cnt_nxt;
         waiting_r <= waiting_nxt;
      end
   end

   always_comb
   begin
      status.master_state_flag   = master_r; // [R19]
      status.start_detected_flag = std_r;
      status.start_failure_flag  = fail_r;
      status.bus_busy_flag       = busy_r;
      status.extension_code_flag = exc_r;
      status.waiting             = waiting_r;
   end

   assign i2c_event_irq   = irq_r;
   assign gen_start       = gen_r;
   assign addr_xfer_start = xfer_r;

endmodule

// ===== verilog/i2c_start_pkg.sv
// Shared constants, states and carrier structs for the start-control block
package i2c_start_pkg;

   // Wait figures in prescaled clocks, and their cycle counts
   localparam int WAIT_STD_CLKS      = 26;
   localparam int WAIT_STD_LOW_CLKS  = 47;
   localparam int WAIT_FAST_CLKS     = 16;
   localparam int WAIT_EXT_CLKS      = 10;
   localparam int FAIL_BASE_CLKS     = 6;
   localparam int FAIL_STEP_CLKS     = 3;
   localparam int FAIL_NOPRE_CLKS    = 3;
   localparam int CNT_W              = 8;

   // Extension code upper nibbles
   localparam logic [3:0] EXT_LOW_NIB  = 4'h0;
   localparam logic [3:0] EXT_HIGH_NIB = 4'hF;

   // Reset values
   localparam logic RST_BUSY      = 1'b0;
   localparam logic RST_MASTER    = 1'b0;

   typedef enum logic [2:0]
   {
      ST_IDLE     = 3'b000,
      ST_DECIDE   = 3'b001,
      ST_RESERVED = 3'b010,
      ST_MASTER   = 3'b011,
      ST_WAIT     = 3'b100
   } start_state_type;

   // Software control bits
   typedef struct packed
   {
      logic       unit_enable;
      logic       start_request;
      logic       stop_request;
      logic       wait_release;
      logic       leave_bus;
      logic       stop_irq_enable;
      logic       reservation_disable;
      logic       start_without_stop_enable;
      logic       fast_mode_select;
      logic       clock_select_high;
      logic       clock_select_low;
      logic       clock_extension_bit;
      logic       prescaler_enable;
      logic [1:0] prescaler_select;
   } ctrl_type;

   // Bus-side events from the shift and condition logic
   typedef struct packed
   {
      logic       start_seen;
      logic       stop_seen;
      logic       addr_done;
      logic [6:0] addr;
      logic       arb_lost;
      logic       data_write;
   } bus_event_type;

   // Status returned to software
   typedef struct packed
   {
      logic master_state_flag;
      logic start_detected_flag;
      logic start_failure_flag;
      logic bus_busy_flag;
      logic extension_code_flag;
      logic waiting;
   } status_type;

endpackage
